// ### hdl/sdc_deframer_ctrl.sv
// sdc_deframer_ctrl: apb register block steering serdes lane settings, sysref gating,
// deframer link enable with lane fifo flush, prbs checking and deframer status.
// assumes deframer core status, sample data and mcs done arrive on CLOCK_IN;
// sysref, lane clock and lane data are asynchronous pins.
// Operation
// - tx swing 0..3, resets to 1
// - tx pre-emphasis 0..2, resets to 0
// - four-bit tx lane polarity flip mask
// - four-bit rx lane polarity flip mask
// - one rx equaliser level, all lanes
// - select deframer 0, 1 or both
// - prbs checker off, 7, 15 or 31
// - lane checking blocks framed link bring-up
// - sample checking uses deframed sample data
// - per-deframer sysref gate, 1 passes
// - realign only on gated sysref rising edge
// - sysref gates pass after reset
// - sequencer withholds sysref until stages done
// - link disable also disables its fifos
// - link enable resets then enables fifos
// - status bit 7 checksum matched
// - status bit 6 end-of-frame error
// - status bit 5 end-of-multiframe error
// - status bit 4 frame symbol error
// - status bit 0 internal sync level
// - status shows sysref received, user data
// - eight-bit status word per deframer
// - lane checker per lane, sample converter 0
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps

module sdc_deframer_ctrl (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [sdc_pkg::SDC_ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // sysref and multichip sync
    input wire logic SYSREF_IN,
    input wire logic MCS_DONE_IN,
    output logic [1:0] SYSREF_PULSE_OUT,
    // receive lanes (asynchronous)
    input wire logic LANE_CLK_IN,
    input wire logic [3:0] LANE_DATA_IN,
    // deframed converter 0 sample stream
    input wire logic SAMPLE_VALID_IN,
    input wire logic SAMPLE_BIT_IN,
    // deframer core status
    input wire sdc_pkg::sdc_dfrm_stat_t [1:0] DFRM_STAT_IN,
    // serdes and link controls
    output sdc_pkg::sdc_serdes_t SERDES_CFG_OUT,
    output logic [1:0] LINK_EN_OUT,
    output logic [3:0] LANE_FIFO_EN_OUT,
    output logic [3:0] LANE_FIFO_RST_OUT
);
    import sdc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        sdc_serdes_t serdes;
        sdc_prbs_t prbs_order;
        logic prbs_at_sample;
        logic [3:0] lane_err;
        logic sample_err;
        logic [3:0][30:0] lane_hist;
        logic [30:0] sample_hist;
        sdc_choice_t stat_choice;
        logic [1:0] gate;
        logic [3:0] lane_owner;
        sdc_link_t [1:0] link_st;
        logic [1:0][3:0] flush_cnt;
        logic [1:0] eof_err;
        logic [1:0] eomf_err;
        logic [1:0] fs_err;
        logic [1:0] sysref_seen;
        logic sref_s1;
        logic sref_s2;
        logic sref_s3;
        logic lclk_s1;
        logic lclk_s2;
        logic lclk_s3;
        logic [3:0] ldata_s1;
        logic [3:0] ldata_s2;
        logic [1:0] sysref_pulse;
        logic [1:0] link_en;
        logic [3:0] fifo_en;
        logic [3:0] fifo_rst;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sdc_state_t;

    sdc_state_t st;
    sdc_state_t next_st;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // polynomial taps
    function automatic logic prbs_predict(input logic [30:0] hist, input sdc_prbs_t ord);
        logic bit_out;
        bit_out = 1'b0;
        unique case (ord)
            SDC_PRBS_7: bit_out = hist[SDC_P7_TAP_A] ^ hist[SDC_P7_TAP_B];
            SDC_PRBS_15: bit_out = hist[SDC_P15_TAP_A] ^ hist[SDC_P15_TAP_B];
            SDC_PRBS_31: bit_out = hist[SDC_P31_TAP_A] ^ hist[SDC_P31_TAP_B];
            SDC_PRBS_OFF: bit_out = 1'b0;
        endcase
        return bit_out;
    endfunction

    // does the choice cover deframer d
    function automatic logic choice_hits(input sdc_choice_t ch, input int d);
        logic hit;
        hit = (ch == SDC_SEL_BOTH) || (ch == SDC_SEL_D0 && d == 0) || (ch == SDC_SEL_D1 && d == 1);
        return hit;
    endfunction

    // eight-bit status word of one deframer
    function automatic logic [7:0] status_word(input sdc_dfrm_stat_t s, input logic eof_e,
                                               input logic eomf_e, input logic fs_e,
                                               input logic sref_seen);
        logic [7:0] w;
        w[7] = s.checksum_ok;
        w[6] = eof_e;
        w[5] = eomf_e;
        w[4] = fs_e;
        w[3] = 1'b0;
        w[2] = s.user_data;
        w[1] = sref_seen;
        w[0] = s.sync_level;
        return w;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic apb_access;
        logic wr_go;
        logic addr_hit;
        logic lclk_rise;
        logic sref_rise;
        logic lane_check;
        logic pred;
        logic bit_in;
        logic [1:0] link_cmd;
        logic link_val;
        logic [31:0] rdata;
        apb_access = 1'b0;
        wr_go = 1'b0;
        addr_hit = 1'b0;
        lclk_rise = 1'b0;
        sref_rise = 1'b0;
        lane_check = 1'b0;
        pred = 1'b0;
        bit_in = 1'b0;
        link_cmd = 2'b00;
        link_val = 1'b0;
        rdata = 32'h0000_0000;
        next_st = st;

        // two-flop synchronisers; edges are taken between stage two and three
        next_st.sref_s1 = SYSREF_IN;
        next_st.sref_s2 = st.sref_s1;
        next_st.sref_s3 = st.sref_s2;
        next_st.lclk_s1 = LANE_CLK_IN;
        next_st.lclk_s2 = st.lclk_s1;
        next_st.lclk_s3 = st.lclk_s2;
        next_st.ldata_s1 = LANE_DATA_IN;
        next_st.ldata_s2 = st.ldata_s1;
        lclk_rise = st.lclk_s2 & ~st.lclk_s3;
        sref_rise = st.sref_s2 & ~st.sref_s3;

        // ------------------------------------------------------------
        // apb: one wait state so read data comes from a flop
        // ------------------------------------------------------------
        apb_access = PSEL_IN & PENABLE_IN;
        wr_go = apb_access & st.pready & PWRITE_IN & ~st.pslverr;
        addr_hit = (PADDR_IN == SDC_ADDR_SERDES) || (PADDR_IN == SDC_ADDR_PRBS) ||
                   (PADDR_IN == SDC_ADDR_DFRM) || (PADDR_IN == SDC_ADDR_STATUS);
        unique case (PADDR_IN)
            SDC_ADDR_SERDES: rdata[15:0] = {2'b00, st.serdes.rx_equaliser_level,
                                            st.serdes.rx_lane_polarity_flip,
                                            st.serdes.tx_lane_polarity_flip,
                                            st.serdes.tx_preemphasis_level,
                                            st.serdes.tx_swing_level};
            SDC_ADDR_PRBS: begin
                rdata[SDC_PRBS_ORDER_LSB +: 2] = st.prbs_order;
                rdata[SDC_PRBS_LOC_BIT] = st.prbs_at_sample;
                rdata[SDC_PRBS_LERR_LSB +: 4] = st.lane_err;
                rdata[SDC_PRBS_SERR_BIT] = st.sample_err;
            end
            SDC_ADDR_DFRM: begin
                rdata[SDC_DFRM_RD_GATE_LSB +: 2] = st.gate;
                rdata[SDC_DFRM_RD_LINK_LSB +: 2] = st.link_en;
                rdata[SDC_DFRM_OWNER_LSB +: 4] = st.lane_owner;
            end
            SDC_ADDR_STATUS: begin
                // status of the chosen deframer, both side by side
                if (st.stat_choice == SDC_SEL_D1) begin
                    rdata[7:0] = status_word(DFRM_STAT_IN[1], st.eof_err[1], st.eomf_err[1],
                                             st.fs_err[1], st.sysref_seen[1]);
                end else begin
                    rdata[7:0] = status_word(DFRM_STAT_IN[0], st.eof_err[0], st.eomf_err[0],
                                             st.fs_err[0], st.sysref_seen[0]);
                end
                if (st.stat_choice == SDC_SEL_BOTH) begin
                    rdata[SDC_STAT_D1_LSB +: 8] = status_word(DFRM_STAT_IN[1], st.eof_err[1],
                                                              st.eomf_err[1], st.fs_err[1],
                                                              st.sysref_seen[1]);
                end
            end
            default: rdata = 32'h0000_0000;
        endcase
        if (apb_access & ~st.pready) begin
            next_st.pready = 1'b1;
            next_st.pslverr = ~addr_hit;
            next_st.prdata = (addr_hit & ~PWRITE_IN) ? rdata : 32'h0000_0000;
        end else begin
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0000_0000;
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_go && PADDR_IN == SDC_ADDR_SERDES) begin
            next_st.serdes.tx_swing_level = PWDATA_IN[SDC_SER_SWING_LSB +: 2];
            // a level above the maximum is ignored
            if (PWDATA_IN[SDC_SER_PREEMPH_LSB +: 2] <= SDC_PREEMPH_MAX) begin
                next_st.serdes.tx_preemphasis_level = PWDATA_IN[SDC_SER_PREEMPH_LSB +: 2];
            end
            next_st.serdes.tx_lane_polarity_flip = PWDATA_IN[SDC_SER_TXPOL_LSB +: 4];
            next_st.serdes.rx_lane_polarity_flip = PWDATA_IN[SDC_SER_RXPOL_LSB +: 4];
            // single equaliser level for all lanes
            next_st.serdes.rx_equaliser_level = PWDATA_IN[SDC_SER_EQ_LSB +: 2];
        end
        if (wr_go && PADDR_IN == SDC_ADDR_PRBS) begin
            next_st.prbs_order = sdc_prbs_t'(PWDATA_IN[SDC_PRBS_ORDER_LSB +: 2]);
            next_st.prbs_at_sample = PWDATA_IN[SDC_PRBS_LOC_BIT];
            if (PWDATA_IN[SDC_PRBS_CLR_BIT]) begin
                next_st.lane_err = 4'h0;
                next_st.sample_err = 1'b0;
            end
        end
        if (wr_go && PADDR_IN == SDC_ADDR_STATUS) begin
            // code 2'b11 is not a choice and keeps the previous one
            if (PWDATA_IN[SDC_DFRM_SEL_LSB +: 2] != 2'b11) begin
                next_st.stat_choice = sdc_choice_t'(PWDATA_IN[SDC_DFRM_SEL_LSB +: 2]);
            end
        end
        if (wr_go && PADDR_IN == SDC_ADDR_DFRM) begin
            next_st.lane_owner = PWDATA_IN[SDC_DFRM_OWNER_LSB +: 4];
            for (int d = 0; d < 2; d++) begin
                if (choice_hits(sdc_choice_t'(PWDATA_IN[SDC_DFRM_SEL_LSB +: 2]), d)) begin
                    if (PWDATA_IN[SDC_DFRM_GATE_WR_BIT]) begin
                        next_st.gate[d] = PWDATA_IN[SDC_DFRM_GATE_VAL_BIT];
                    end
                    link_cmd[d] = PWDATA_IN[SDC_DFRM_LINK_WR_BIT];
                end
            end
            link_val = PWDATA_IN[SDC_DFRM_LINK_VAL_BIT];
        end

        // ------------------------------------------------------------
        // link state per deframer
        // ------------------------------------------------------------
        for (int d = 0; d < 2; d++) begin
            if (link_cmd[d] && !link_val) begin
                // disable drops the link and its fifos together
                next_st.link_st[d] = SDC_LNK_OFF;
            end else if (link_cmd[d] && link_val) begin
                // every enable starts with a fifo flush
                next_st.link_st[d] = SDC_LNK_FLUSH;
                next_st.flush_cnt[d] = SDC_FLUSH_CYCLES;
                next_st.eof_err[d] = 1'b0;
                next_st.eomf_err[d] = 1'b0;
                next_st.fs_err[d] = 1'b0;
                next_st.sysref_seen[d] = 1'b0;
            end else begin
                unique case (st.link_st[d])
                    SDC_LNK_OFF: next_st.link_st[d] = SDC_LNK_OFF;
                    SDC_LNK_FLUSH: begin
                        // fifos re-enabled once the flush has run out
                        if (st.flush_cnt[d] == 4'h1) begin
                            next_st.link_st[d] = SDC_LNK_ON;
                        end
                        next_st.flush_cnt[d] = st.flush_cnt[d] - 4'h1;
                    end
                    SDC_LNK_ON: next_st.link_st[d] = SDC_LNK_ON;
                    default: next_st.link_st[d] = SDC_LNK_OFF;
                endcase
            end
            // error events captured; capture wins over the enable clear
            if (DFRM_STAT_IN[d].frame_end_error) begin
                next_st.eof_err[d] = 1'b1;
            end
            if (DFRM_STAT_IN[d].end_of_multiframe_error) begin
                next_st.eomf_err[d] = 1'b1;
            end
            if (DFRM_STAT_IN[d].frame_symbol_error) begin
                next_st.fs_err[d] = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // sysref distribution
        // ------------------------------------------------------------
        for (int d = 0; d < 2; d++) begin
            // only a gated rising edge after the sequencer is done
            next_st.sysref_pulse[d] = sref_rise & st.gate[d] & MCS_DONE_IN;
            // sysref seen stays until the next link enable
            if (next_st.sysref_pulse[d]) begin
                next_st.sysref_seen[d] = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // prbs checking
        // ------------------------------------------------------------
        lane_check = (st.prbs_order != SDC_PRBS_OFF) & ~st.prbs_at_sample;
        if (lane_check && lclk_rise) begin
            for (int l = 0; l < 4; l++) begin
                bit_in = st.ldata_s2[l] ^ st.serdes.rx_lane_polarity_flip[l];
                pred = prbs_predict(st.lane_hist[l], st.prbs_order);
                if (pred != bit_in) begin
                    next_st.lane_err[l] = 1'b1;
                end
                next_st.lane_hist[l] = {st.lane_hist[l][29:0], bit_in};
            end
        end
        // sample checking on converter 0 output only
        if ((st.prbs_order != SDC_PRBS_OFF) && st.prbs_at_sample && SAMPLE_VALID_IN) begin
            pred = prbs_predict(st.sample_hist, st.prbs_order);
            if (pred != SAMPLE_BIT_IN) begin
                next_st.sample_err = 1'b1;
            end
            next_st.sample_hist = {st.sample_hist[29:0], SAMPLE_BIT_IN};
        end

        // ------------------------------------------------------------
        // outputs, aligned with the new link state
        // ------------------------------------------------------------
        for (int d = 0; d < 2; d++) begin
            // raw lane checking keeps the framed link down
            next_st.link_en[d] = (next_st.link_st[d] == SDC_LNK_ON) & ~lane_check;
        end
        for (int l = 0; l < 4; l++) begin
            // each lane follows the deframer that owns it
            next_st.fifo_en[l] = next_st.link_st[next_st.lane_owner[l]] == SDC_LNK_ON;
            next_st.fifo_rst[l] = next_st.link_st[next_st.lane_owner[l]] == SDC_LNK_FLUSH;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st <= '0;
            st.serdes.tx_swing_level <= SDC_SWING_RST;
            st.serdes.tx_preemphasis_level <= SDC_PREEMPH_RST;
            st.gate <= SDC_GATE_RST;
            st.lane_owner <= SDC_OWNER_RST;
            st.prbs_order <= SDC_PRBS_OFF;
            st.stat_choice <= SDC_SEL_D0;
            st.link_st[0] <= SDC_LNK_OFF;
            st.link_st[1] <= SDC_LNK_OFF;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // ports
    // ----------------------------------------------------------------
    assign PRDATA_OUT = st.prdata;
    assign PREADY_OUT = st.pready;
    assign PSLVERR_OUT = st.pslverr;
    assign SYSREF_PULSE_OUT = st.sysref_pulse;
    assign SERDES_CFG_OUT = st.serdes;
    assign LINK_EN_OUT = st.link_en;
    assign LANE_FIFO_EN_OUT = st.fifo_en;
    assign LANE_FIFO_RST_OUT = st.fifo_rst;

endmodule

// ### shared/sdc_pkg.sv
// sdc_pkg: constants and types for the deframer control and status block.
// assumes a 32-bit apb register bus and two deframers sharing four receive lanes.
package sdc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int SDC_ADDR_W = 8;
    localparam logic [7:0] SDC_ADDR_SERDES = 8'h00;
    localparam logic [7:0] SDC_ADDR_PRBS = 8'h04;
    localparam logic [7:0] SDC_ADDR_DFRM = 8'h08;
    localparam logic [7:0] SDC_ADDR_STATUS = 8'h0C;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SDC_SER_SWING_LSB = 0;
    localparam int SDC_SER_PREEMPH_LSB = 2;
    localparam int SDC_SER_TXPOL_LSB = 4;
    localparam int SDC_SER_RXPOL_LSB = 8;
    localparam int SDC_SER_EQ_LSB = 12;
    localparam int SDC_PRBS_ORDER_LSB = 0;
    localparam int SDC_PRBS_LOC_BIT = 4;
    localparam int SDC_PRBS_LERR_LSB = 8;
    localparam int SDC_PRBS_SERR_BIT = 12;
    localparam int SDC_PRBS_CLR_BIT = 16;
    localparam int SDC_DFRM_SEL_LSB = 0;
    localparam int SDC_DFRM_GATE_WR_BIT = 4;
    localparam int SDC_DFRM_GATE_VAL_BIT = 5;
    localparam int SDC_DFRM_LINK_WR_BIT = 8;
    localparam int SDC_DFRM_LINK_VAL_BIT = 9;
    localparam int SDC_DFRM_OWNER_LSB = 16;
    localparam int SDC_DFRM_RD_GATE_LSB = 0;
    localparam int SDC_DFRM_RD_LINK_LSB = 2;
    localparam int SDC_STAT_D1_LSB = 8;

    // ----------------------------------------------------------------
    // reset values and limits
    // ----------------------------------------------------------------
    localparam logic [1:0] SDC_SWING_RST = 2'h1;
    localparam logic [1:0] SDC_PREEMPH_RST = 2'h0;
    localparam logic [1:0] SDC_PREEMPH_MAX = 2'h2;
    localparam logic [1:0] SDC_GATE_RST = 2'h3;
    localparam logic [3:0] SDC_OWNER_RST = 4'h0;
    localparam logic [3:0] SDC_FLUSH_CYCLES = 4'h8;

    // ----------------------------------------------------------------
    // prbs feedback taps (history bit 0 is the newest bit)
    // ----------------------------------------------------------------
    localparam int SDC_P7_TAP_A = 6;
    localparam int SDC_P7_TAP_B = 5;
    localparam int SDC_P15_TAP_A = 14;
    localparam int SDC_P15_TAP_B = 13;
    localparam int SDC_P31_TAP_A = 30;
    localparam int SDC_P31_TAP_B = 27;

    // ----------------------------------------------------------------
    // enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SDC_SEL_D0 = 2'b00,
        SDC_SEL_D1 = 2'b01,
        SDC_SEL_BOTH = 2'b10
    } sdc_choice_t;

    typedef enum logic [1:0] {
        SDC_PRBS_OFF = 2'b00,
        SDC_PRBS_7 = 2'b01,
        SDC_PRBS_15 = 2'b10,
        SDC_PRBS_31 = 2'b11
    } sdc_prbs_t;

    typedef enum logic [1:0] {
        SDC_LNK_OFF = 2'b00,
        SDC_LNK_FLUSH = 2'b01,
        SDC_LNK_ON = 2'b10
    } sdc_link_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rx_equaliser_level;
        logic [3:0] rx_lane_polarity_flip;
        logic [3:0] tx_lane_polarity_flip;
        logic [1:0] tx_preemphasis_level;
        logic [1:0] tx_swing_level;
    } sdc_serdes_t;

    // per-deframer core status; the three error members are one-cycle event pulses
    typedef struct packed {
        logic checksum_ok;
        logic frame_end_error;
        logic end_of_multiframe_error;
        logic frame_symbol_error;
        logic user_data;
        logic sync_level;
    } sdc_dfrm_stat_t;

endpackage

// ### verif/sdc_checker.sv
// sdc_checker: port assertions for the deframer control block.
// assumes owners stay at deframer 0; mcs done is read one edge before the pulse shows.
`timescale 1ns/100ps
module sdc_checker (
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic SYSREF_IN,
    input wire logic MCS_DONE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [1:0] SYSREF_PULSE_OUT,
    input wire sdc_pkg::sdc_serdes_t SERDES_CFG_OUT,
    input wire logic [3:0] LANE_FIFO_EN_OUT,
    input wire logic [3:0] LANE_FIFO_RST_OUT
);
    import sdc_pkg::*;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);
    property p_wait; PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT; endproperty
    a_wait: assert property (p_wait) else $error("late ready");
    property p_once; PREADY_OUT |=> !PREADY_OUT; endproperty
    a_once: assert property (p_once) else $error("ready held");
    property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_idle; !PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_pre; SERDES_CFG_OUT.tx_preemphasis_level != 2'h3; endproperty
    a_pre: assert property (p_pre) else $error("bad emphasis");
    property p_edge; |SYSREF_PULSE_OUT |-> $past(SYSREF_IN, 3) && !$past(SYSREF_IN, 4); endproperty
    a_edge: assert property (p_edge) else $error("realign without edge");
    property p_mcs; |SYSREF_PULSE_OUT |-> $past(MCS_DONE_IN, 1); endproperty
    a_mcs: assert property (p_mcs) else $error("sysref before sync");
    property p_flush; $rose(LANE_FIFO_RST_OUT[0]) |-> LANE_FIFO_RST_OUT[0] [*8] ##1 LANE_FIFO_EN_OUT[0]; endproperty
    a_flush: assert property (p_flush) else $error("bad flush");
    c_flush: cover property ($rose(LANE_FIFO_EN_OUT[0]));
    c_sref: cover property (SYSREF_PULSE_OUT == 2'b01);
    c_err: cover property (PSLVERR_OUT);
endmodule
bind sdc_deframer_ctrl sdc_checker i_sdc_checker (.*);

// ### verif/sdc_lane_model.sv
// sdc_lane_model: lane source sending prbs7 on all four lanes.
// assumes a free-running lane clock, as a recovered serial clock is.
`timescale 1ns/100ps
module sdc_lane_model (
    output logic lane_clk_out = 1'b0,
    output logic [3:0] lane_data_out = 4'h0
);
    logic [6:0] hist = 7'h7F;
    always #62.5 begin
        if (lane_clk_out) begin
            hist = {hist[5:0], hist[6] ^ hist[5]};
            lane_data_out = {4{hist[0]}};
        end
        lane_clk_out = ~lane_clk_out;
    end
endmodule

// ### verif/tb_top.sv
// tb_top: scenario bench for the deframer control block.
// assumes the checker binds itself; owners stay at deframer 0.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: %h, expected %h", $time, a, e); end end
module tb_top;
    import sdc_pkg::*;
    logic clk, rstn = 0, psel = 0, pen = 0, pwr = 0, sref = 0, multichip_sync_sequencer = 0, lclk, pready, pslverr, er;
    logic svalid = 0, sbit = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [1:0] spulse, linken, seen;
    logic [3:0] ldata, fen, frst;
    sdc_serdes_t cfg;
    sdc_dfrm_stat_t [1:0] stat = '0;
    int n_mismatch = 0, check_count = 0;
    sdc_deframer_ctrl i_sdc_deframer_ctrl (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .SYSREF_IN(sref), .MCS_DONE_IN(multichip_sync_sequencer), .SYSREF_PULSE_OUT(spulse),
        .LANE_CLK_IN(lclk), .LANE_DATA_IN(ldata), .SAMPLE_VALID_IN(svalid), .SAMPLE_BIT_IN(sbit),
        .DFRM_STAT_IN(stat), .SERDES_CFG_OUT(cfg), .LINK_EN_OUT(linken), .LANE_FIFO_EN_OUT(fen),
        .LANE_FIFO_RST_OUT(frst));
    sdc_lane_model i_sdc_lane_model (.lane_clk_out(lclk), .lane_data_out(ldata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n++ < 40) @(posedge clk);
        if (pready !== 1'b1) n_mismatch++;
        {er, rd} = {pslverr, prdata};
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic sysref(input logic [1:0] exp);
        seen = 2'b00;
        sref <= 1'b1;
        repeat (10) @(posedge clk) seen |= spulse;
        sref <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(seen, exp)
    endtask
    task automatic t_regs;
        `CHK(cfg, 14'h0001)
        apb(1'b0, SDC_ADDR_DFRM, '0);
        `CHK(rd[3:0], 4'h3)
        apb(1'b1, SDC_ADDR_SERDES, 32'h0000_3FF7);
        apb(1'b1, SDC_ADDR_SERDES, 32'h0000_3FFF);
        `CHK(cfg, 14'h3FF7)
        apb(1'b0, 8'h10, '0);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        $display("regs done");
    endtask
    task automatic t_link;
        // lanes arrive uninverted, so the lane checkers must start clean
        apb(1'b1, SDC_ADDR_SERDES, 32'h0000_0001);
        apb(1'b1, SDC_ADDR_DFRM, 32'h0000_0300);
        repeat (12) @(posedge clk);
        `CHK({linken, fen, frst}, 10'b01_1111_0000)
        apb(1'b1, SDC_ADDR_DFRM, 32'h0000_0100);
        @(posedge clk);
        `CHK({linken, fen}, 6'h00)
        apb(1'b1, SDC_ADDR_DFRM, 32'h0000_0302);
        repeat (12) @(posedge clk);
        `CHK(linken, 2'b11)
        for (int o = 3; o > 0; o--) begin
            apb(1'b1, SDC_ADDR_PRBS, 32'(o));
            @(posedge clk);
            `CHK(linken, 2'b00)
        end
        repeat (900) @(posedge clk);
        apb(1'b1, SDC_ADDR_PRBS, 32'h0001_0001);
        repeat (300) @(posedge clk);
        apb(1'b0, SDC_ADDR_PRBS, '0);
        `CHK(rd[11:0], 12'h001)
        apb(1'b1, SDC_ADDR_SERDES, 32'h0000_0501);
        repeat (300) @(posedge clk);
        apb(1'b0, SDC_ADDR_PRBS, '0);
        `CHK(rd[11:8], 4'h5)
        apb(1'b1, SDC_ADDR_PRBS, '0);
        // an all-zero sample stream fits every pattern; one set bit must be flagged
        svalid <= 1'b1;
        apb(1'b1, SDC_ADDR_PRBS, 32'h0001_0011);
        apb(1'b0, SDC_ADDR_PRBS, '0);
        `CHK({linken, rd[12:0]}, {2'b11, 13'h0011})
        sbit <= 1'b1;
        apb(1'b0, SDC_ADDR_PRBS, '0);
        `CHK(rd[12], 1'b1)
        apb(1'b1, SDC_ADDR_PRBS, '0);
        $display("link done");
    endtask
    task automatic t_sysref;
        sysref(2'b00);
        multichip_sync_sequencer <= 1'b1;
        sysref(2'b11);
        apb(1'b1, SDC_ADDR_DFRM, 32'h0000_0011);
        sysref(2'b01);
        $display("sysref done");
    endtask
    task automatic t_status;
        stat <= {6'b011000, 6'b100111};
        @(posedge clk);
        stat <= {6'b000000, 6'b100011};
        apb(1'b1, SDC_ADDR_STATUS, 32'h0000_0002);
        apb(1'b0, SDC_ADDR_STATUS, '0);
        `CHK(rd[15:0], 16'h6297)
        apb(1'b1, SDC_ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, SDC_ADDR_STATUS, 32'h0000_0003);
        apb(1'b0, SDC_ADDR_STATUS, '0);
        `CHK(rd[7:0], 8'h62)
        $display("status done");
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_link();
        t_sysref();
        t_status();
        results();
    end
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule
